// ===== rtl/ipc_arbiter.sv
// three tier interrupt arbiter with in-service tracking
`timescale 1ns/100ps
module ipc_arbiter (
  input logic i_sys_clk,
  input logic i_sys_rst,
  ipc_arb_if.arb arb
);
  import ipc_pkg::*;

  typedef struct packed {
    logic [2:0] in_svc;
    logic req;
    logic [3:0] idx;
    ipc_tier_t tier;
  } ipc_arb_st_t;

  ipc_arb_st_t st_q;
  ipc_arb_st_t st_d;

  // lowest numbered set bit wins inside a tier
  function automatic logic [3:0] ipc_first(input logic [NUM_SRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : ipc_first

  logic [2:0] svc;
  logic [NUM_SRC-1:0] hi_v;
  logic [NUM_SRC-1:0] lo_v;
  logic sup_v;

  always_comb begin
    st_d = st_q;
    svc = st_q.in_svc;
    // return from service closes the innermost (highest) active tier
    if (arb.reti) begin
      if (svc[2]) begin
        svc[2] = 1'b0;
      end else if (svc[1]) begin
        svc[1] = 1'b0;
      end else begin
        svc[0] = 1'b0;
      end
    end
    if (arb.ack && st_q.req) begin
      svc[st_q.tier] = 1'b1;
    end
    st_d.in_svc = svc;
    sup_v = arb.req_vec[SRC_SUPPLY];
    hi_v = arb.req_vec & arb.tier_hi;
    hi_v[SRC_SUPPLY] = 1'b0;
    lo_v = arb.req_vec & ~arb.tier_hi;
    lo_v[SRC_SUPPLY] = 1'b0;
    // a tier only interrupts service of strictly lower tiers
    if (svc[2]) begin
      sup_v = 1'b0;
      hi_v = '0;
      lo_v = '0;
    end else if (svc[1]) begin
      hi_v = '0;
      lo_v = '0;
    end else if (svc[0]) begin
      lo_v = '0;
    end
    st_d.req = sup_v | (|hi_v) | (|lo_v);
    if (sup_v) begin
      st_d.idx = 4'(SRC_SUPPLY);
      st_d.tier = IPC_TIER_SUPPLY;
    end else if (|hi_v) begin
      st_d.idx = ipc_first(hi_v);
      st_d.tier = IPC_TIER_HIGH;
    end else begin
      st_d.idx = ipc_first(lo_v);
      st_d.tier = IPC_TIER_LOW;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= '{in_svc: 3'h0, req: 1'b0, idx: 4'h0, tier: IPC_TIER_LOW};
    end else begin
      st_q <= st_d;
    end
  end

  assign arb.grant_req = st_q.req;
  assign arb.grant_idx = st_q.idx;
  assign arb.grant_tier = st_q.tier;
endmodule : ipc_arbiter

// ===== rtl/ipc_top.sv
// interrupt enable, priority and pin configuration registers with request arbitration
`timescale 1ns/100ps
module ipc_top #(
  parameter int unsigned P_CAL_HALF0 = ipc_pkg::CAL_HALF0,
  parameter int unsigned P_CAL_HALF1 = ipc_pkg::CAL_HALF1,
  parameter int unsigned P_CAL_HALF2 = ipc_pkg::CAL_HALF2,
  parameter int unsigned P_CAL_HALF3 = ipc_pkg::CAL_HALF3
) (
  input logic i_sys_clk,
  input logic i_sys_rst,
  input logic [7:0] i_sfr_addr,
  input logic i_sfr_wr,
  input logic [7:0] i_sfr_wdata,
  input logic i_sfr_rd,
  output logic [7:0] o_sfr_rdata,
  input logic [ipc_pkg::NUM_SRC-1:0] i_irq_pending,
  input logic i_irq_ack,
  input logic i_irq_reti,
  output logic o_irq_req,
  output logic [3:0] o_irq_index,
  output ipc_pkg::ipc_tier_t o_irq_tier,
  output logic o_rtc_cal_output_enable,
  output logic o_rtc_cal_out,
  output logic [2:0] o_ext_irq1_pin_function,
  output logic o_ext_irq0_pin_function
);
  import ipc_pkg::*;

  typedef struct packed {
    logic [7:0] pri_en;
    logic [7:0] prio;
    logic [7:0] sec;
    logic [7:0] pin_cfg;
    logic [7:0] rdata;
    logic [CAL_CNT_W-1:0] cal_cnt;
    logic cal_lvl;
  } ipc_st_t;

  ipc_st_t st_q;
  ipc_st_t st_d;

  ipc_arb_if arb_if ();

  ipc_arbiter u_arb (
    .i_sys_clk (i_sys_clk),
    .i_sys_rst (i_sys_rst),
    .arb (arb_if.arb)
  );

  // reserved bits keep their reset value whatever is written
  function automatic logic [7:0] ipc_wmask(input logic [7:0] wd, input logic [7:0] mask,
                                           input logic [7:0] rstv);
    return (wd & ~mask) | (rstv & mask);
  endfunction : ipc_wmask

  typedef enum logic [2:0] {IPC_SEL_NONE, IPC_SEL_PRI_EN, IPC_SEL_PRIO, IPC_SEL_SEC,
                            IPC_SEL_PIN} ipc_sel_t;

  // one decode serves both strobes; an unmapped address selects nothing, so a stray
  // write is dropped and a stray read gives zero
  function automatic ipc_sel_t ipc_dec(input logic [7:0] a);
    ipc_sel_t s;
    s = IPC_SEL_NONE;
    if (a == PRI_EN_ADDR) begin
      s = IPC_SEL_PRI_EN;
    end else if (a == PRIO_ADDR) begin
      s = IPC_SEL_PRIO;
    end else if (a == SEC_ADDR) begin
      s = IPC_SEL_SEC;
    end else if (a == PIN_CFG_ADDR) begin
      s = IPC_SEL_PIN;
    end
    return s;
  endfunction : ipc_dec

  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] tier_hi;
  logic ext1_live;
  logic [CAL_CNT_W-1:0] cal_top;
  logic [1:0] cal_sel;
  ipc_sel_t reg_sel;

  // per-source enables and tiers gathered from the three registers
  always_comb begin
    src_en = '0;
    src_en[6:0] = st_q.pri_en[6:0];
    src_en[SRC_EXT0] = st_q.pri_en[EXT0_EN_BIT];
    src_en[SRC_METER] = st_q.sec[METER_EN_BIT];
    src_en[SRC_RTC] = st_q.sec[RTC_EN_BIT];
    src_en[SRC_SERIAL] = st_q.sec[SER_EN_BIT];
    src_en[SRC_SUPPLY] = st_q.sec[SUPPLY_EN_BIT];
    tier_hi = '0;
    tier_hi[7:0] = st_q.prio;
    tier_hi[SRC_RTC] = st_q.sec[RTC_PRIO_BIT];
    tier_hi[SRC_SERIAL] = st_q.sec[SER_PRIO_BIT];
  end

  // ext1 only reaches the arbiter when its pin is set up as an enabled input
  assign ext1_live = (st_q.pin_cfg[EXT1_FN_LSB+2:EXT1_FN_LSB+1] == 2'b11);

  always_comb begin
    arb_if.req_vec = i_irq_pending & src_en & {NUM_SRC{st_q.pri_en[GLOBAL_EN_BIT]}};
    if (!ext1_live) begin
      arb_if.req_vec[2] = 1'b0;
    end
  end

  assign arb_if.tier_hi = tier_hi;
  assign arb_if.ack = i_irq_ack;
  assign arb_if.reti = i_irq_reti;

  assign cal_sel = st_q.pin_cfg[CAL_SEL_LSB+1:CAL_SEL_LSB];
  assign reg_sel = ipc_dec(i_sfr_addr);

  always_comb begin
    case (cal_sel)
      2'b00: cal_top = CAL_CNT_W'(P_CAL_HALF0 - 1);
      2'b01: cal_top = CAL_CNT_W'(P_CAL_HALF1 - 1);
      2'b10: cal_top = CAL_CNT_W'(P_CAL_HALF2 - 1);
      default: cal_top = CAL_CNT_W'(P_CAL_HALF3 - 1);
    endcase
  end

  always_comb begin
    st_d = st_q;
    if (i_sfr_wr) begin
      if (reg_sel == IPC_SEL_PRI_EN) begin
        st_d.pri_en = i_sfr_wdata;
      end else if (reg_sel == IPC_SEL_PRIO) begin
        st_d.prio = i_sfr_wdata;
      end else if (reg_sel == IPC_SEL_SEC) begin
        st_d.sec = ipc_wmask(i_sfr_wdata, SEC_RSVD_MASK, SEC_RST);
      end else if (reg_sel == IPC_SEL_PIN) begin
        st_d.pin_cfg = ipc_wmask(i_sfr_wdata, PIN_RSVD_MASK, PIN_CFG_RST);
      end
    end
    // read data is captured one edge after the read strobe; unmapped reads give zero
    if (i_sfr_rd) begin
      if (reg_sel == IPC_SEL_PRI_EN) begin
        st_d.rdata = st_q.pri_en;
      end else if (reg_sel == IPC_SEL_PRIO) begin
        st_d.rdata = st_q.prio;
      end else if (reg_sel == IPC_SEL_SEC) begin
        st_d.rdata = st_q.sec;
      end else if (reg_sel == IPC_SEL_PIN) begin
        st_d.rdata = st_q.pin_cfg;
      end else begin
        st_d.rdata = 8'h00;
      end
    end
    // the divider idles low when off; the >= compare absorbs a smaller
    // period chosen mid-count without a long wrap
    if (!st_q.pin_cfg[CAL_EN_BIT]) begin
      st_d.cal_cnt = '0;
      st_d.cal_lvl = 1'b0;
    end else if (st_q.cal_cnt >= cal_top) begin
      st_d.cal_cnt = '0;
      st_d.cal_lvl = ~st_q.cal_lvl;
    end else begin
      st_d.cal_cnt = st_q.cal_cnt + CAL_CNT_W'(1);
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      st_q <= '{pri_en: PRI_EN_RST, prio: PRIO_RST, sec: SEC_RST, pin_cfg: PIN_CFG_RST,
                rdata: 8'h00, cal_cnt: '0, cal_lvl: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign o_sfr_rdata = st_q.rdata;
  assign o_irq_req = arb_if.grant_req;
  assign o_irq_index = arb_if.grant_idx;
  assign o_irq_tier = arb_if.grant_tier;
  assign o_rtc_cal_output_enable = st_q.pin_cfg[CAL_EN_BIT];
  assign o_rtc_cal_out = st_q.cal_lvl;
  assign o_ext_irq1_pin_function = st_q.pin_cfg[EXT1_FN_LSB+2:EXT1_FN_LSB];
  assign o_ext_irq0_pin_function = st_q.pin_cfg[EXT0_FN_BIT];
endmodule : ipc_top

// ===== shared/ipc_arb_if.sv
// carrier between the register file and the tier arbiter
`timescale 1ns/100ps
interface ipc_arb_if;
  import ipc_pkg::*;
  logic [NUM_SRC-1:0] req_vec;
  logic [NUM_SRC-1:0] tier_hi;
  logic ack;
  logic reti;
  logic grant_req;
  logic [3:0] grant_idx;
  ipc_tier_t grant_tier;
  modport regs (output req_vec, tier_hi, ack, reti, input grant_req, grant_idx, grant_tier);
  modport arb (input req_vec, tier_hi, ack, reti, output grant_req, grant_idx, grant_tier);
endinterface : ipc_arb_if

// ===== shared/ipc_pkg.sv
// constants and types of the interrupt priority and pin configuration block
package ipc_pkg;
  localparam logic [7:0] PRI_EN_ADDR = 8'ha8;
  localparam logic [7:0] PRIO_ADDR = 8'hb8;
  localparam logic [7:0] SEC_ADDR = 8'ha9;
  localparam logic [7:0] PIN_CFG_ADDR = 8'hff;

  localparam logic [7:0] PRI_EN_RST = 8'h00;
  localparam logic [7:0] PRIO_RST = 8'h00;
  localparam logic [7:0] SEC_RST = 8'ha0;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] SEC_RSVD_MASK = 8'ha0;
  localparam logic [7:0] PIN_RSVD_MASK = 8'h10;

  localparam int GLOBAL_EN_BIT = 7;
  localparam int EXT0_EN_BIT = 0;
  localparam int RTC_PRIO_BIT = 6;
  localparam int SER_PRIO_BIT = 4;
  localparam int METER_EN_BIT = 3;
  localparam int RTC_EN_BIT = 2;
  localparam int SUPPLY_EN_BIT = 1;
  localparam int SER_EN_BIT = 0;
  localparam int CAL_EN_BIT = 7;
  localparam int CAL_SEL_LSB = 5;
  localparam int EXT1_FN_LSB = 1;
  localparam int EXT0_FN_BIT = 0;

  // source numbering; 0..6 follow the primary enable bit order and 0..7 the priority bit order
  localparam int SRC_EXT0 = 0;
  localparam int SRC_METER = 7;
  localparam int SRC_RTC = 8;
  localparam int SRC_SERIAL = 9;
  localparam int SRC_SUPPLY = 10;
  localparam int NUM_SRC = 11;

  typedef enum logic [1:0] {IPC_TIER_LOW, IPC_TIER_HIGH, IPC_TIER_SUPPLY} ipc_tier_t;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned CAL_F0_HZ = 1;
  localparam int unsigned CAL_F1_HZ = 512;
  localparam int unsigned CAL_F2_HZ = 500;
  localparam int unsigned CAL_F3_HZ = 16384;
  localparam int unsigned CAL_HALF0 = CLK_HZ / (2 * CAL_F0_HZ);
  localparam int unsigned CAL_HALF1 = CLK_HZ / (2 * CAL_F1_HZ);
  localparam int unsigned CAL_HALF2 = CLK_HZ / (2 * CAL_F2_HZ);
  localparam int unsigned CAL_HALF3 = CLK_HZ / (2 * CAL_F3_HZ);
  localparam int CAL_CNT_W = 26;
endpackage : ipc_pkg

// ===== tb/ipc_checker.sv
// assertions on the ports of the interrupt configuration block
`timescale 1ns/100ps
module ipc_checker (
  input logic i_sys_clk,
  input logic i_sys_rst,
  input logic [7:0] i_sfr_addr,
  input logic i_sfr_wr,
  input logic [7:0] i_sfr_wdata,
  input logic i_sfr_rd,
  input logic [7:0] o_sfr_rdata,
  input logic [ipc_pkg::NUM_SRC-1:0] i_irq_pending,
  input logic o_irq_req,
  input logic [3:0] o_irq_index,
  input ipc_pkg::ipc_tier_t o_irq_tier,
  input logic o_rtc_cal_output_enable,
  input logic o_rtc_cal_out,
  input logic [2:0] o_ext_irq1_pin_function
);
  import ipc_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_wr(a);
    i_sfr_wr && i_sfr_addr == a;
  endsequence
  a_cal_en_load: assert property (
    s_wr(8'hff) |=> o_rtc_cal_output_enable == $past(i_sfr_wdata[7])) else $error("cal enable");
  a_cal_out_quiet: assert property (
    !o_rtc_cal_output_enable [*2] |-> !o_rtc_cal_out) else $error("cal out not idle");
  a_ext1_fn_load: assert property (
    s_wr(8'hff) |=> o_ext_irq1_pin_function == $past(i_sfr_wdata[3:1])) else $error("ext1 fn");
  a_sec_rsvd_read: assert property (
    i_sfr_rd && i_sfr_addr == 8'ha9 |=> o_sfr_rdata[7] && o_sfr_rdata[5]) else $error("sec rsvd");
  a_pin_rsvd_read: assert property (
    i_sfr_rd && i_sfr_addr == 8'hff |=> !o_sfr_rdata[4]) else $error("pin rsvd");
  a_req_has_pend: assert property (
    o_irq_req |-> ($past(i_irq_pending) & (11'h1 << o_irq_index)) != 0) else $error("no pend");
  a_ext1_gated: assert property (
    o_irq_req && o_irq_index == 4'd2 |-> $past(o_ext_irq1_pin_function[2:1]) == 2'b11)
    else $error("ext1 request while pin not enabled");
  a_supply_tier_only: assert property (
    o_irq_req |-> (o_irq_index == 4'd10) == (o_irq_tier == IPC_TIER_SUPPLY)) else $error("tier");
  a_global_mask_all: assert property (
    s_wr(8'ha8) ##0 !i_sfr_wdata[7] ##1 !(i_sfr_wr && i_sfr_addr == 8'ha8) |=> !o_irq_req)
    else $error("req while masked");
endmodule : ipc_checker
bind ipc_top ipc_checker i_ipc_checker (.i_sys_clk, .i_sys_rst, .i_sfr_addr, .i_sfr_wr,
  .i_sfr_wdata, .i_sfr_rd, .o_sfr_rdata, .i_irq_pending, .o_irq_req, .o_irq_index,
  .o_irq_tier, .o_rtc_cal_output_enable, .o_rtc_cal_out, .o_ext_irq1_pin_function);

// ===== tb/ipc_core_model.sv
// processor core model that takes and returns from interrupts
`timescale 1ns/100ps
module ipc_core_model (
  input logic i_sys_clk,
  input logic i_sys_rst,
  input logic i_take,
  input logic i_slow,
  input logic i_ret,
  input logic i_irq_req,
  output logic o_ack,
  output logic o_reti
);
  logic [1:0] wait_q = 2'h0;
  // acks only a standing request; a slow core lets it stand three more cycles
  always @(posedge i_sys_clk) begin
    o_reti <= i_ret && !i_sys_rst;
    o_ack <= !i_sys_rst && i_irq_req && i_take && !o_ack && (!i_slow || wait_q == 2'h3);
    wait_q <= (i_sys_rst || !(i_irq_req && i_take) || o_ack) ? 2'h0 : wait_q + 2'h1;
  end
endmodule : ipc_core_model

// ===== tb/tb.sv
// self-checking bench for the interrupt configuration block
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module tb;
  import ipc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [NUM_SRC-1:0] pend = '0;
  logic take = 1'b0;
  logic slow = 1'b0;
  logic ret = 1'b0;
  logic ack, reti, req, cal_en, cal_out, fn0;
  logic [7:0] rdata;
  logic [3:0] idx;
  logic [2:0] fn1;
  ipc_tier_t tier;
  int mismatches = 0;
  int total_checks = 0;
  logic [15:0] rst_tab [5] = '{16'ha800, 16'hb800, 16'ha9a0, 16'hff00, 16'h1000};
  logic [23:0] wr_tab [7] = '{24'hb8a5a5, 24'hb85a5a, 24'ha95fff, 24'ha900a0, 24'hffffef,
    24'h10ff00, 24'ha88181};
  int halves [4] = '{8, 6, 5, 3};
  always #4 clk = ~clk;
  ipc_top #(.P_CAL_HALF0(8), .P_CAL_HALF1(6), .P_CAL_HALF2(5), .P_CAL_HALF3(3)) i_ipc_top (
    .i_sys_clk(clk), .i_sys_rst(rst), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
    .i_sfr_rd(rd), .o_sfr_rdata(rdata), .i_irq_pending(pend), .i_irq_ack(ack),
    .i_irq_reti(reti), .o_irq_req(req), .o_irq_index(idx), .o_irq_tier(tier),
    .o_rtc_cal_output_enable(cal_en), .o_rtc_cal_out(cal_out),
    .o_ext_irq1_pin_function(fn1), .o_ext_irq0_pin_function(fn0));
  ipc_core_model i_ipc_core_model (.i_sys_clk(clk), .i_sys_rst(rst), .i_take(take),
    .i_slow(slow), .i_ret(ret), .i_irq_req(req), .o_ack(ack), .o_reti(reti));
  task automatic print_verdict();
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict
  // every access ends one idle edge later so strobes never toggle twice in a step
  task automatic wrt(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wrt
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    `CHK("rdata", e, rdata)
  endtask : rdc
  task automatic irq(input logic r, input logic [3:0] i, input ipc_tier_t t);
    repeat (3) @(posedge clk);
    `CHK("req", r, req)
    if (r) begin
      `CHK("index", i, idx)
      `CHK("tier", t, tier)
    end
  endtask : irq
  task automatic serve(input logic s);
    int n;
    n = 0;
    slow <= s;
    take <= 1'b1;
    while (ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    take <= 1'b0;
    `CHK("ack", 1'b1, ack)
  endtask : serve
  task automatic rtn();
    ret <= 1'b1;
    @(posedge clk);
    ret <= 1'b0;
    @(posedge clk);
  endtask : rtn
  task automatic cal(input int code, input int half);
    int n;
    logic v;
    wrt(8'hff, 8'h80 | 8'(code << 5));
    for (int k = 0; k < 2; k++) begin
      n = 0;
      v = cal_out;
      while (cal_out === v && n < 40) begin
        @(posedge clk);
        n++;
      end
    end
    `CHK("cal_half", half, n)
  endtask : cal
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rst_tab[k])
      rdc(rst_tab[k][15:8], rst_tab[k][7:0]);
    foreach (wr_tab[k]) begin
      wrt(wr_tab[k][23:16], wr_tab[k][15:8]);
      rdc(wr_tab[k][23:16], wr_tab[k][7:0]);
    end
    wrt(8'hff, 8'h5b);
    `CHK("ext1_fn", 3'h5, fn1)
    `CHK("cal_en", 1'b0, cal_en)
    `CHK("ext0_fn", 1'b1, fn0)
    for (int c = 0; c < 4; c++)
      cal(c, halves[c]);
    wrt(8'hff, 8'h00);
    wrt(8'ha9, 8'h0a);
    wrt(8'hb8, 8'h80);
    wrt(8'ha8, 8'h83);
    pend <= 11'h003;
    irq(1'b1, 4'd0, IPC_TIER_LOW);
    serve(1'b0);
    irq(1'b0, 4'd0, IPC_TIER_LOW);
    pend <= 11'h083;
    irq(1'b1, 4'd7, IPC_TIER_HIGH);
    serve(1'b1);
    pend <= 11'h483;
    irq(1'b1, 4'd10, IPC_TIER_SUPPLY);
    serve(1'b0);
    pend <= 11'h003;
    rtn();
    rtn();
    irq(1'b0, 4'd0, IPC_TIER_LOW);
    rtn();
    irq(1'b1, 4'd0, IPC_TIER_LOW);
    wrt(8'ha8, 8'h03);
    irq(1'b0, 4'd0, IPC_TIER_LOW);
    wrt(8'ha8, 8'h82);
    irq(1'b1, 4'd1, IPC_TIER_LOW);
    wrt(8'ha9, 8'h45);
    pend <= 11'h303;
    irq(1'b1, 4'd8, IPC_TIER_HIGH);
    wrt(8'ha9, 8'h15);
    irq(1'b1, 4'd9, IPC_TIER_HIGH);
    wrt(8'ha8, 8'h84);
    pend <= 11'h004;
    irq(1'b0, 4'd0, IPC_TIER_LOW);
    wrt(8'hff, 8'h0c);
    irq(1'b1, 4'd2, IPC_TIER_LOW);
    print_verdict();
  end
endmodule : tb
